// ### common/power_meter_defines.svh
// Purpose: Offsets, fields, reset values and codes of the power meter block
// Assumes: AXI4-Lite register access, 32-bit words
// Notes:   Definitions only
`ifndef POWER_METER_DEFINES_SVH
`define POWER_METER_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFS_CTRL     8'h00
`define OFS_SEL      8'h04
`define OFS_VALUE    8'h08
`define OFS_STATUS   8'h0c
`define OFS_CMD      8'h10
`define OFS_CT       8'h14
`define OFS_VT       8'h18
`define OFS_LIM0     8'h1c
`define OFS_IRQ_ST   8'h38
`define OFS_IRQ_MASK 8'h3c
`define OFS_SEQ      8'h40
`define LIM_COUNT    7

// ==========================================================
// Fields, codes and reset values
`define CTRL_FLOAT   0
`define CTRL_LITTLE  1
`define CMD_ACK      8'h04
`define STATUS_RST   16'h0100
`define FACTOR_RST   16'h0001
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

// ==========================================================
// Measurand ids
`define ID_EGY_C     6'd1
`define ID_EGY_P     6'd2
`define ID_EGY_LAST  6'd8
`define ID_PWR_LAST  6'd11
`define ID_FREQ      6'd12
`define ID_TEMP      6'd14
`define ID_V1        6'd18
`define ID_OVF_C     6'd39
`define ID_OVF_P     6'd40
`define ID_STATUS    6'd41
`define ID_PHASE_STEP 6'd8

// ==========================================================
// Float magnitude ceilings
`define FLT_EGY_MAX  31'h4e03126e
`define FLT_PWR_MAX  31'h4a031270

`endif

// ### common/power_meter_pkg.sv
// Purpose: Types of the power meter block
// Assumes: Used with power_meter_defines.svh
// Notes:   State structs, one per clocked module
package power_meter_pkg;

  typedef logic [31:0] word_t;

  typedef struct packed {
    word_t pre;
    word_t cnt;
    word_t ovf;
  } egy_st_t;

  typedef struct packed {
    logic             aw_h;
    logic [7:0]       aw_a;
    logic             w_h;
    word_t            w_d;
    logic [3:0]       w_s;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    word_t            rdata;
    logic [1:0]       ctrl;
    logic [5:0]       sel;
    logic [15:0]      ct;
    logic [15:0]      vt;
    logic [6:0][31:0] lim;
    logic [1:0]       irq_st;
    logic [1:0]       irq_mask;
    word_t            seq;
    logic [15:0]      pend;
    logic [15:0]      status;
    logic [41:0][31:0] imem;
    logic [41:0][31:0] fmem;
  } meter_st_t;

endpackage

// ### logic/energy_prescaler.sv
// Purpose: Energy counter stepping once per factor-scaled watt-hour
// Assumes: tick is one primary watt-hour
// Notes:   Overflow count only runs in integer mode
`timescale 1ns/1ps
`default_nettype none
module energy_prescaler
  import power_meter_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        count_ovf,
  input  wire logic [15:0] ct,
  input  wire logic [15:0] vt,
  output logic      [31:0] count,
  output logic      [31:0] ovf
);
  egy_st_t st_ff;
  egy_st_t nxt_st;
  word_t   step;

  // ==========================================================
  // Prescaler and counters
  always_comb
  begin
    nxt_st = st_ff;
    step   = ct * vt;
    if (step == 32'h0)
      step = 32'h1;
    if (tick)
    begin
      if (st_ff.pre + 32'h1 >= step)
      begin
        nxt_st.pre = 32'h0;
        nxt_st.cnt = st_ff.cnt + 32'h1;
        if (&st_ff.cnt && count_ovf)
          nxt_st.ovf = st_ff.ovf + 32'h1;
      end
      else
        nxt_st.pre = st_ff.pre + 32'h1;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign count = st_ff.cnt;
  assign ovf   = st_ff.ovf;
endmodule // energy_prescaler
`default_nettype wire

// ### logic/limit_checker.sv
// Purpose: Limit comparison of one incoming measurement
// Assumes: Integer-unit values; limits ordered Vlo Vhi Ihi PFlo Tmax Fmin Fmax
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "power_meter_defines.svh"
module limit_checker
  import power_meter_pkg::*;
(
  input  wire logic [5:0]       id,
  input  wire logic [31:0]      value,
  input  wire logic [6:0][31:0] lim,
  output logic      [15:0]      viol
);
  // ==========================================================
  // Per phase voltage, current and power factor checks
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_phase
      localparam logic [5:0] VID = `ID_V1 + 6'(p) * `ID_PHASE_STEP;
      localparam int         LOB = (p == 0) ? 15 : p - 1;
      assign viol[LOB]    = (id == VID) && (value < lim[0]);
      assign viol[2 + p]  = (id == VID) && (value > lim[1]);
      assign viol[9 + p]  = (id == VID + 6'd1) && (value > lim[2]);
      assign viol[12 + p] = (id == VID + 6'd2)
                            && ($signed(value) < $signed(lim[3]));
    end
  endgenerate

  // Temperature, frequency, reset flag slot
  assign viol[5] = (id == `ID_TEMP) && ($signed(value) > $signed(lim[4]));
  assign viol[6] = (id == `ID_FREQ) && (value < lim[5]);
  assign viol[7] = (id == `ID_FREQ) && (value > lim[6]);
  assign viol[8] = 1'b0;
endmodule // limit_checker
`default_nettype wire

// ### logic/power_meter.sv
// Purpose: Measurand readout by id with limit status word and interrupt
// Assumes: Measurement source writes values, then pulses set_done
// Notes:   AXI4-Lite slave, one outstanding write and read
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "power_meter_defines.svh"
module power_meter
  import power_meter_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  input  wire logic        meas_wr,
  input  wire logic [5:0]  meas_id,
  input  wire logic [31:0] meas_int,
  input  wire logic [31:0] meas_flt,
  input  wire logic        set_done,
  input  wire logic [1:0]  energy_tick,
  output logic      [15:0] limit_lamp,
  output logic             irq,
  output logic      [31:0] data_set_sequence_counter
);
  meter_st_t        st_ff;
  meter_st_t        nxt_st;
  logic [1:0][31:0] egy_cnt;
  logic [1:0][31:0] egy_ovf;
  logic [15:0]      viol;
  logic [15:0]      pend_all;
  logic             aw_hs;
  logic             w_hs;
  logic             ar_hs;
  logic             do_wr;
  logic             ack;
  logic             float_mode;
  word_t            wd_m;
  word_t            sel_val;
  word_t            rd_val;

  // ==========================================================
  // Helpers
  function automatic word_t merge(word_t old, word_t nw, logic [3:0] s);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // Clamp of float values to their documented range
  function automatic word_t fclamp(logic [5:0] id, word_t v);
    word_t r;
    r = v;
    if (id <= `ID_EGY_LAST)
    begin
      if (v[31])
        r = 32'h0;
      else if (v[30:0] > `FLT_EGY_MAX)
        r = {1'b0, `FLT_EGY_MAX};
    end
    else if (id <= `ID_PWR_LAST && v[30:0] > `FLT_PWR_MAX)
      r = {v[31], `FLT_PWR_MAX};
    return r;
  endfunction

  // ==========================================================
  // Sub blocks
  genvar e;
  generate
    for (e = 0; e < 2; e++)
    begin : g_egy
      energy_prescaler u_egy (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .tick      (energy_tick[e]),
        .count_ovf (!float_mode),
        .ct        (st_ff.ct),
        .vt        (st_ff.vt),
        .count     (egy_cnt[e]),
        .ovf       (egy_ovf[e])
      );
    end
  endgenerate

  limit_checker u_chk (
    .id    (meas_id),
    .value (meas_int),
    .lim   (st_ff.lim),
    .viol  (viol)
  );

  // ==========================================================
  // Handshakes and outputs
  assign float_mode = st_ff.ctrl[`CTRL_FLOAT];
  assign awready = !st_ff.aw_h && !st_ff.bvalid;
  assign wready  = !st_ff.w_h && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign ar_hs   = arvalid && arready;
  assign do_wr   = st_ff.aw_h && st_ff.w_h && !st_ff.bvalid;
  assign wd_m    = merge(32'h0, st_ff.w_d, st_ff.w_s);
  assign ack     = do_wr && st_ff.aw_a == `OFS_CMD
                   && wd_m[7:0] == `CMD_ACK;
  assign pend_all = st_ff.pend | (meas_wr ? viol : 16'h0);
  assign bvalid  = st_ff.bvalid;
  assign bresp   = st_ff.bresp;
  assign rvalid  = st_ff.rvalid;
  assign rresp   = st_ff.rresp;
  assign rdata   = st_ff.rdata;
  assign limit_lamp = st_ff.status & ~`STATUS_RST;
  assign irq     = |(st_ff.irq_st & st_ff.irq_mask);
  assign data_set_sequence_counter = st_ff.seq;

  // ==========================================================
  // Value of the selected measurand
  always_comb
  begin
    sel_val = 32'h0;
    if (st_ff.sel == `ID_STATUS)
      sel_val = {16'h0, st_ff.status};
    else if (st_ff.sel == 6'd0 || st_ff.sel > `ID_STATUS)
      sel_val = 32'h0;
    else if (!float_mode)
    begin
      case (st_ff.sel)
        `ID_EGY_C: sel_val = egy_cnt[0];
        `ID_EGY_P: sel_val = egy_cnt[1];
        `ID_OVF_C: sel_val = egy_ovf[0];
        `ID_OVF_P: sel_val = egy_ovf[1];
        default:   sel_val = st_ff.imem[st_ff.sel];
      endcase
    end
    else if (st_ff.sel == `ID_OVF_C || st_ff.sel == `ID_OVF_P)
      sel_val = 32'h0;
    else
      sel_val = fclamp(st_ff.sel, st_ff.fmem[st_ff.sel]);
    if (st_ff.ctrl[`CTRL_LITTLE])
      sel_val = {sel_val[7:0], sel_val[15:8], sel_val[23:16], sel_val[31:24]};
  end

  // Read mux by address
  always_comb
  begin
    rd_val = 32'h0;
    if (araddr >= `OFS_LIM0 && araddr < `OFS_IRQ_ST && araddr[1:0] == 2'b00)
      rd_val = st_ff.lim[3'(araddr[7:2] - 6'd7)];
    else
    begin
      case (araddr)
        `OFS_CTRL:     rd_val = {30'h0, st_ff.ctrl};
        `OFS_SEL:      rd_val = {26'h0, st_ff.sel};
        `OFS_VALUE:    rd_val = sel_val;
        `OFS_STATUS:   rd_val = {16'h0, st_ff.status};
        `OFS_CT:       rd_val = {16'h0, st_ff.ct};
        `OFS_VT:       rd_val = {16'h0, st_ff.vt};
        `OFS_IRQ_ST:   rd_val = {30'h0, st_ff.irq_st};
        `OFS_IRQ_MASK: rd_val = {30'h0, st_ff.irq_mask};
        `OFS_SEQ:      rd_val = st_ff.seq;
        default:       rd_val = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    // Write channel capture
    if (aw_hs)
    begin
      nxt_st.aw_h = 1'b1;
      nxt_st.aw_a = awaddr;
    end
    if (w_hs)
    begin
      nxt_st.w_h = 1'b1;
      nxt_st.w_d = wdata;
      nxt_st.w_s = wstrb;
    end
    if (st_ff.bvalid && bready)
      nxt_st.bvalid = 1'b0;
    // Register write effects
    if (do_wr)
    begin
      nxt_st.aw_h   = 1'b0;
      nxt_st.w_h    = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = `RESP_OKAY;
      if (st_ff.aw_a >= `OFS_LIM0 && st_ff.aw_a < `OFS_IRQ_ST
          && st_ff.aw_a[1:0] == 2'b00)
        nxt_st.lim[3'(st_ff.aw_a[7:2] - 6'd7)] =
          merge(st_ff.lim[3'(st_ff.aw_a[7:2] - 6'd7)], st_ff.w_d, st_ff.w_s);
      else
      begin
        case (st_ff.aw_a)
          `OFS_CTRL:     nxt_st.ctrl = wd_m[1:0] | (st_ff.ctrl & ~{2{st_ff.w_s[0]}});
          `OFS_SEL:      nxt_st.sel = st_ff.w_s[0] ? wd_m[5:0] : st_ff.sel;
          `OFS_CMD:      nxt_st.bresp = `RESP_OKAY;
          `OFS_CT:       nxt_st.ct = 16'(merge({16'h0, st_ff.ct}, st_ff.w_d, st_ff.w_s));
          `OFS_VT:       nxt_st.vt = 16'(merge({16'h0, st_ff.vt}, st_ff.w_d, st_ff.w_s));
          `OFS_IRQ_ST:   nxt_st.irq_st = st_ff.irq_st & ~wd_m[1:0];
          `OFS_IRQ_MASK: nxt_st.irq_mask = wd_m[1:0] | (st_ff.irq_mask & ~{2{st_ff.w_s[0]}});
          `OFS_VALUE, `OFS_STATUS, `OFS_SEQ: nxt_st.bresp = `RESP_OKAY;
          default:       nxt_st.bresp = `RESP_SLVERR;
        endcase
      end
    end
    // Read channel
    if (st_ff.rvalid && rready)
      nxt_st.rvalid = 1'b0;
    if (ar_hs)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = (araddr > `OFS_SEQ || araddr[1:0] != 2'b00) ? `RESP_SLVERR
                                                                   : `RESP_OKAY;
    end
    // Measurement storage
    if (meas_wr && meas_id != 6'd0 && meas_id < `ID_STATUS)
    begin
      nxt_st.imem[meas_id] = meas_int;
      nxt_st.fmem[meas_id] = meas_flt;
    end
    // Pending flags fold into the status word at each new data set
    nxt_st.pend = set_done ? 16'h0 : pend_all;
    if (set_done)
      nxt_st.seq = st_ff.seq + 32'h1;
    nxt_st.status = (ack ? 16'h0 : st_ff.status)
                    | (set_done ? pend_all : 16'h0);
    // Sticky interrupt events, set wins over clear
    if (set_done)
      nxt_st.irq_st[0] = 1'b1;
    if (set_done && |(pend_all & ~st_ff.status))
      nxt_st.irq_st[1] = 1'b1;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff        <= '0;
      st_ff.status <= `STATUS_RST;
      st_ff.ct     <= `FACTOR_RST;
      st_ff.vt     <= `FACTOR_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rst_flag;
    $rose(aresetn) |-> st_ff.status == `STATUS_RST;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset flag missing");

  property p_ack;
    ack && !set_done |=> st_ff.status == 16'h0 && limit_lamp == 16'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear flags");

  property p_sticky;
    !ack |=> (st_ff.status & $past(st_ff.status)) == $past(st_ff.status);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_refresh;
    !set_done && !ack |=> $stable(st_ff.status);
  endproperty
  a_refresh: assert property (p_refresh) else $error("status moved off set");

  property p_word41;
    ar_hs && araddr == `OFS_VALUE && st_ff.sel == `ID_STATUS && !st_ff.ctrl[1]
      |=> rdata == {16'h0, $past(st_ff.status)};
  endproperty
  a_word41: assert property (p_word41) else $error("status word wrong");

  property p_ovf_float;
    ar_hs && araddr == `OFS_VALUE && float_mode && st_ff.sel == `ID_OVF_C
      |=> rdata == 32'h0;
  endproperty
  a_ovf_float: assert property (p_ovf_float) else $error("overflow in float");

  property p_pwr_clamp;
    ar_hs && araddr == `OFS_VALUE && float_mode && !st_ff.ctrl[1]
      && st_ff.sel == 6'd9 |=> rdata[30:0] <= `FLT_PWR_MAX;
  endproperty
  a_pwr_clamp: assert property (p_pwr_clamp) else $error("power clamp");

  property p_egy_clamp;
    ar_hs && araddr == `OFS_VALUE && float_mode && !st_ff.ctrl[1]
      && st_ff.sel != 6'd0 && st_ff.sel <= `ID_EGY_LAST
      |=> !rdata[31] && rdata[30:0] <= `FLT_EGY_MAX;
  endproperty
  a_egy_clamp: assert property (p_egy_clamp) else $error("energy clamp");

  property p_v3_high;
    meas_wr && meas_id == 6'd34 && meas_int > st_ff.lim[1]
      |=> st_ff.pend[4] || st_ff.status[4];
  endproperty
  a_v3_high: assert property (p_v3_high) else $error("V3 high not flagged");

  property p_id0;
    ar_hs && araddr == `OFS_VALUE && st_ff.sel == 6'd0 |=> rdata == 32'h0;
  endproperty
  a_id0: assert property (p_id0) else $error("id 0 not zero");

  c_set: cover property (set_done ##1 st_ff.status != 16'h0);
  c_ack: cover property (ack ##1 st_ff.status == 16'h0);
  c_irq: cover property ($rose(irq));
endmodule // power_meter
`default_nettype wire

// ### tb/meas_feed.sv
// Purpose: Measurement source that feeds values and data set ends to the meter
// Assumes: Driven from the bench through its tasks, one call at a time
// Notes:   Released value lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module meas_feed
  import power_meter_pkg::*;
(
  input  wire logic        aclk,
  output logic             meas_wr,
  output logic      [5:0]  meas_id,
  output logic      [31:0] meas_int,
  output logic      [31:0] meas_flt,
  output logic             set_done,
  output logic      [1:0]  energy_tick
);
  // ==========================================================
  // Idle levels at time zero
  initial
  begin
    meas_wr     = 1'b0;
    meas_id     = 6'h00;
    meas_int    = 32'h0;
    meas_flt    = 32'h0;
    set_done    = 1'b0;
    energy_tick = 2'b00;
  end

  // One value in integer and float form, one cycle wide
  task automatic put(input logic [5:0] id, input word_t vi, input word_t vf);
    @(posedge aclk);
    meas_wr  <= 1'b1;
    meas_id  <= id;
    meas_int <= vi;
    meas_flt <= vf;
    @(posedge aclk);
    meas_wr  <= 1'b0;
    meas_id  <= ~id;
    meas_int <= ~vi;
    meas_flt <= ~vf;
  endtask

  // Data set end, advances the sequence counter
  task automatic done();
    @(posedge aclk);
    set_done <= 1'b1;
    @(posedge aclk);
    set_done <= 1'b0;
  endtask

  // Primary watt-hour pulses, one every other cycle
  task automatic tick(input logic [1:0] b, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      energy_tick <= b;
      @(posedge aclk);
      energy_tick <= 2'b00;
    end
  endtask
endmodule // meas_feed
`default_nettype wire

// ### tb/power_meter_float_values_and_limit_flags_test.sv
// Purpose: Register-level bench of the meter over AXI4-Lite
// Assumes: Register map and latencies of the meter hand-over
// Notes:   Limit flags, float clamping, byte order, interrupt, faults
`timescale 1ns/1ps
`default_nettype none
`include "power_meter_defines.svh"
module power_meter_float_values_and_limit_flags_test
  import power_meter_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic        arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seq;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, etick, rsp;
  logic        mwr, sdone, irq;
  logic [5:0]  mid;
  logic [31:0] mint, mflt, rdv;
  logic [15:0] limit_lamp;
  int          err_count = 0, checked = 0, nd = 0;
  logic [5:0]  tid [14] = '{6'd26, 6'd34, 6'd18, 6'd26, 6'd14, 6'd12, 6'd12, 6'd19,
                            6'd27, 6'd35, 6'd20, 6'd28, 6'd36, 6'd18};
  word_t       tval [14] = '{100, 100, 2000, 2000, 2000, 100, 7000, 2000, 2000, 2000,
                             10, 10, 10, 100};
  int          tbit [14] = '{0, 1, 2, 3, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15};
  word_t       lims [7] = '{500, 1000, 1000, 50, 1000, 4600, 6400};
  logic [5:0]  fid [6] = '{6'd9, 6'd10, 6'd3, 6'd4, 6'd39, 6'd21};
  word_t       fin [6] = '{32'h4b000000, 32'hcb000000, 32'h4f000000, 32'hbf800000,
                           32'h3f800000, 32'h3f800000};
  word_t       fexp [6] = '{32'h4a031270, 32'hca031270, 32'h4e03126e, 32'h0,
                            32'h0, 32'h3f800000};

  // ==========================================================
  // Clock and design
  always #4 aclk = ~aclk;

  power_meter u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .meas_wr(mwr), .meas_id(mid), .meas_int(mint), .meas_flt(mflt), .set_done(sdone),
    .energy_tick(etick), .limit_lamp(limit_lamp), .irq(irq),
    .data_set_sequence_counter(seq));

  meas_feed u_feed (.aclk(aclk), .meas_wr(mwr), .meas_id(mid), .meas_int(mint),
    .meas_flt(mflt), .set_done(sdone), .energy_tick(etick));

  // ==========================================================
  // Verdict and compares
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(input word_t got, input word_t exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: response %b expected %b", $time, got, exp);
    end
  endtask

  task automatic stall();
    err_count++;
    $display("Error at %0t: bus answer timed out", $time);
    end_sim();
  endtask

  // ==========================================================
  // Bus cycles, handshakes judged on settled values before each edge
  task automatic wr(input logic [7:0] a, input word_t d, output logic [1:0] r);
    int   n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    while (!tb && n < 40)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r  = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
        bready <= 1'b0;
      n++;
    end
    if (!tb)
      stall();
  endtask

  task automatic rd(input logic [7:0] a, output word_t d, output logic [1:0] r);
    int   n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!tr && n < 40)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
        rready <= 1'b0;
      n++;
    end
    if (!tr)
      stall();
  endtask

  // Write expecting OKAY; read expecting OKAY and a value
  task automatic w(input logic [7:0] a, input word_t d);
    wr(a, d, rsp);
    chk_resp(rsp, `RESP_OKAY);
  endtask

  task automatic rc(input logic [7:0] a, input word_t exp);
    rd(a, rdv, rsp);
    chk_resp(rsp, `RESP_OKAY);
    chk_word(rdv, exp);
  endtask

  // Lamp and interrupt levels, sampled mid-cycle
  task automatic pins(input logic [15:0] lamp, input logic i);
    @(negedge aclk);
    chk_word({16'h0, limit_lamp}, {16'h0, lamp});
    chk_word({31'h0, irq}, {31'h0, i});
  endtask

  task automatic meas(input logic [5:0] id, input word_t vi, input word_t vf);
    u_feed.put(id, vi, vf);
    u_feed.done();
    nd++;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`OFS_STATUS, 32'h00000100);
    rc(`OFS_VALUE, 32'h0);
    pins(16'h0000, 1'b0);
    // Energy step of 2 x 3 primary watt-hours
    w(`OFS_CT, 32'h2);
    w(`OFS_VT, 32'h3);
    u_feed.tick(2'b01, 12);
    w(`OFS_SEL, 32'h1);
    rc(`OFS_VALUE, 32'h2);
    for (int i = 0; i < 7; i++)
      w(`OFS_LIM0 + 8'(4 * i), lims[i]);
    w(`OFS_IRQ_MASK, 32'h2);
    // Flag appears only at the data set end, then sticks
    u_feed.put(6'd34, 32'd2000, 32'h0);
    rc(`OFS_STATUS, 32'h00000100);
    u_feed.done();
    nd++;
    rc(`OFS_STATUS, 32'h00000110);
    pins(16'h0010, 1'b1);
    meas(6'd34, 32'd800, 32'h0);
    rc(`OFS_STATUS, 32'h00000110);
    w(`OFS_CMD, {24'h0, `CMD_ACK});
    rc(`OFS_STATUS, 32'h0);
    w(`OFS_IRQ_ST, 32'h3);
    meas(6'd34, 32'd800, 32'h0);
    pins(16'h0000, 1'b0);
    rc(`OFS_IRQ_ST, 32'h1);
    // Every limit flag position except bit 4 (V3 high, checked above)
    for (int i = 0; i < 14; i++)
    begin
      w(`OFS_CMD, {24'h0, `CMD_ACK});
      meas(tid[i], tval[i], 32'h0);
      rc(`OFS_STATUS, 32'h1 << tbit[i]);
    end
    rc(`OFS_SEQ, word_t'(nd));
    chk_word(seq, word_t'(nd));
    // Integer value of a stored measurand
    w(`OFS_SEL, 32'd18);
    rc(`OFS_VALUE, 32'd100);
    // Float values with clamping
    w(`OFS_CTRL, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      meas(fid[i], 32'h0, fin[i]);
      w(`OFS_SEL, {26'h0, fid[i]});
      rc(`OFS_VALUE, fexp[i]);
    end
    w(`OFS_SEL, 32'd41);
    rc(`OFS_VALUE, 32'h00008000);
    // Little-endian value, status word unaffected
    w(`OFS_CTRL, 32'h3);
    w(`OFS_SEL, 32'd21);
    rc(`OFS_VALUE, 32'h0000803f);
    rc(`OFS_STATUS, 32'h00008000);
    // Unmapped place and read-only word
    wr(8'h80, 32'h1, rsp);
    chk_resp(rsp, `RESP_SLVERR);
    rd(8'h80, rdv, rsp);
    chk_resp(rsp, `RESP_SLVERR);
    chk_word(rdv, 32'h0);
    w(`OFS_STATUS, 32'hffffffff);
    rc(`OFS_STATUS, 32'h00008000);
    // Second reset sets the reset flag again
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`OFS_STATUS, 32'h00000100);
    pins(16'h0000, 1'b0);
    end_sim();
  end
endmodule // power_meter_float_values_and_limit_flags_test
`default_nettype wire
